// ### fcs_pkg.sv
// Constants and types shared by the flash card command sequencer host.
package fcs_pkg;

  // ----------------------------------------------------------------------
  // Card address and data layout
  // ----------------------------------------------------------------------
  localparam int LOC_W = 18;
  localparam int ADDR_W = LOC_W + 1;
  localparam int LANE_BIT = 0;
  localparam int WAIT_W = 21;
  localparam int TRY_W = 10;
  localparam logic [ADDR_W-1:0] ID_MAKER_ADDR = 19'h00000;
  localparam logic [ADDR_W-1:0] ID_PART_ADDR = 19'h00001;
  localparam logic [ADDR_W-1:0] ODD_BANK_START = 19'h00001;
  localparam logic [ADDR_W-1:0] LOC_STEP = 19'h00002;

  // ----------------------------------------------------------------------
  // Command codes and data patterns
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_EVFY = 8'hA0;
  localparam logic [7:0] CMD_PSETUP = 8'h40;
  localparam logic [7:0] CMD_PVFY = 8'hC0;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ERASED_VALUE = 8'hFF;
  localparam logic [7:0] PRE_VALUE = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int WE_LOW_NS = 50;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_NS = 250;
  localparam int ACC_CYC = (ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_CYC = 2;
  localparam int REC_US = 6;
  localparam int REC_CYC = (REC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PGM_PULSE_US = 10;
  localparam int PGM_PULSE_CYC =
    (PGM_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_PULSE_MS = 10;
  localparam int ERASE_PULSE_CYC_DFLT =
    (ERASE_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PGM_MAX_TRY = 25;
  localparam int ERASE_MAX_TRY = 1000;

  // ----------------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ,
    OP_IDENT_MAKER,
    OP_IDENT_PART,
    OP_PROGRAM,
    OP_ERASE,
    OP_RESET
  } fcs_op_t;

endpackage

// ### fcs_host_sequencer.sv
// Host that drives a flash card segment through its command register pins.
//
// Contract
// - Erase-verify command ends running erase.
// - Verify location goes with each command.
// - Rewrite erase-verify before every location.
// - Even bank fully before odd bank.
// - Program all zeros before erasing.
// - Verify walks upward from lowest address.
// - On failure re-erase, resume there.
// - Leave erase-verify with valid command.
// - Reset code twice after program set-up.
`timescale 1ns/1ps
module fcs_host_sequencer #(
  parameter int unsigned ERASE_PULSE_CYC = fcs_pkg::ERASE_PULSE_CYC_DFLT
) (
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  input wire logic REQ_VALID_IN,
  input wire fcs_pkg::fcs_op_t REQ_OP_IN,
  input wire logic [fcs_pkg::ADDR_W-1:0] REQ_ADDR_IN,
  input wire logic [fcs_pkg::LOC_W-1:0] REQ_LAST_IN,
  input wire logic [7:0] REQ_DATA_IN,
  input wire logic [7:0] CARD_DATA_IN,
  output logic REQ_READY_OUT,
  output logic DONE_OUT,
  output logic FAIL_OUT,
  output logic [7:0] RESULT_OUT,
  output logic [fcs_pkg::ADDR_W-1:0] CARD_ADDR_OUT,
  output logic [7:0] CARD_DATA_OUT,
  output logic CARD_DATA_OE_OUT,
  output logic CARD_WE_N_OUT,
  output logic CARD_OE_N_OUT,
  output logic CARD_CE_N_OUT,
  output logic CARD_VPP_EN_OUT
);
  import fcs_pkg::*;

  typedef enum logic [2:0] {B_IDLE, B_SETUP, B_STROBE, B_HOLD, B_READ}
    fcs_bus_t;
  typedef enum logic [4:0] {
    M_IDLE, M_BUS, M_WAIT, M_RD_ISSUE, M_RD_DONE, M_PGM_SETUP, M_PGM_DATA,
    M_PGM_VFY, M_PGM_READ, M_PGM_CHECK, M_ERS_SETUP, M_ERS_GO, M_EV_CMD,
    M_EV_READ, M_EV_CHECK, M_RST1, M_RST2, M_END, M_ID_CMD
  } fcs_main_t;

  fcs_bus_t bus_st;
  fcs_main_t st;
  fcs_main_t ret;
  fcs_op_t op;
  logic [5:0] bus_cnt;
  logic bus_go;
  logic bus_rd;
  logic bus_done;
  logic [ADDR_W-1:0] bus_addr;
  logic [7:0] bus_data;
  logic [7:0] rd_data;
  logic [7:0] card_data_meta;
  logic [7:0] card_data_sync;
  logic [WAIT_W-1:0] wait_cnt;
  logic [ADDR_W-1:0] addr;
  logic [LOC_W-1:0] last;
  logic [7:0] val;
  logic [TRY_W-1:0] tries;
  logic pre;

  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SRST_IN);

  // ----------------------------------------------------------------------
  // Card data synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    card_data_meta <= CARD_DATA_IN;
    card_data_sync <= card_data_meta;
  end

  // ----------------------------------------------------------------------
  // Pin cycle engine
  // ----------------------------------------------------------------------
  // Address is driven one cycle before the strobe falls so the card sees a
  // settled value on the falling edge; data stays driven past the rise.
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      bus_st <= B_IDLE;
      bus_cnt <= 6'h00;
      bus_done <= 1'b0;
      rd_data <= 8'h00;
      CARD_ADDR_OUT <= '0;
      CARD_DATA_OUT <= 8'h00;
      CARD_DATA_OE_OUT <= 1'b0;
      CARD_WE_N_OUT <= 1'b1;
      CARD_OE_N_OUT <= 1'b1;
      CARD_CE_N_OUT <= 1'b1;
    end else begin
      bus_done <= 1'b0;
      case (bus_st)
        B_IDLE: begin
          if (bus_go) begin
            CARD_ADDR_OUT <= bus_addr;
            CARD_CE_N_OUT <= 1'b0;
            bus_cnt <= 6'h00;
            if (bus_rd) begin
              CARD_OE_N_OUT <= 1'b0;
              bus_st <= B_READ;
            end else begin
              CARD_DATA_OUT <= bus_data;
              CARD_DATA_OE_OUT <= 1'b1;
              bus_st <= B_SETUP;
            end
          end
        end
        B_SETUP: begin
          CARD_WE_N_OUT <= 1'b0;
          bus_st <= B_STROBE;
        end
        B_STROBE: begin
          if (bus_cnt == 6'(WE_LOW_CYC - 1)) begin
            CARD_WE_N_OUT <= 1'b1;
            bus_st <= B_HOLD;
          end else begin
            bus_cnt <= bus_cnt + 6'h01;
          end
        end
        B_HOLD: begin
          CARD_DATA_OE_OUT <= 1'b0;
          CARD_CE_N_OUT <= 1'b1;
          bus_done <= 1'b1;
          bus_st <= B_IDLE;
        end
        B_READ: begin
          if (bus_cnt == 6'(ACC_CYC + SYNC_CYC)) begin
            rd_data <= card_data_sync;
            CARD_OE_N_OUT <= 1'b1;
            CARD_CE_N_OUT <= 1'b1;
            bus_done <= 1'b1;
            bus_st <= B_IDLE;
          end else begin
            bus_cnt <= bus_cnt + 6'h01;
          end
        end
        default: bus_st <= B_IDLE;
      endcase
    end
  end

  we_pulse_a: assert property ($fell(CARD_WE_N_OUT) |->
    !CARD_WE_N_OUT [*7] ##1 CARD_WE_N_OUT)
    else $error("write strobe low time is wrong");
  addr_steady_a: assert property (!CARD_WE_N_OUT |->
    $stable(CARD_ADDR_OUT) && !CARD_CE_N_OUT)
    else $error("address moved while strobe low");

  // ----------------------------------------------------------------------
  // Command sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      st <= M_IDLE;
      ret <= M_IDLE;
      op <= OP_READ;
      bus_go <= 1'b0;
      bus_rd <= 1'b0;
      bus_addr <= '0;
      bus_data <= 8'h00;
      wait_cnt <= '0;
      addr <= '0;
      last <= '0;
      val <= 8'h00;
      tries <= '0;
      pre <= 1'b0;
      REQ_READY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      FAIL_OUT <= 1'b0;
      RESULT_OUT <= 8'h00;
      CARD_VPP_EN_OUT <= 1'b0;
    end else begin
      bus_go <= 1'b0;
      DONE_OUT <= 1'b0;
      case (st)
        M_IDLE: begin
          REQ_READY_OUT <= 1'b1;
          if (REQ_VALID_IN && REQ_READY_OUT) begin
            REQ_READY_OUT <= 1'b0;
            FAIL_OUT <= 1'b0;
            op <= REQ_OP_IN;
            addr <= REQ_ADDR_IN;
            last <= REQ_LAST_IN;
            val <= REQ_DATA_IN;
            tries <= '0;
            pre <= 1'b0;
            case (REQ_OP_IN)
              OP_PROGRAM, OP_ERASE: begin
                // The card ignores program and erase while the supply is low.
                CARD_VPP_EN_OUT <= 1'b1;
                wait_cnt <= WAIT_W'(REC_CYC);
                ret <= M_PGM_SETUP;
                st <= M_WAIT;
                if (REQ_OP_IN == OP_ERASE) begin
                  pre <= 1'b1;
                  addr <= '0;
                  val <= PRE_VALUE;
                end
              end
              OP_RESET: st <= M_RST1;
              OP_IDENT_MAKER, OP_IDENT_PART: begin
                // A low supply holds the card's command register in read
                // mode, so the identify code would be lost without it.
                CARD_VPP_EN_OUT <= 1'b1;
                wait_cnt <= WAIT_W'(REC_CYC);
                ret <= M_ID_CMD;
                st <= M_WAIT;
                addr <= (REQ_OP_IN == OP_IDENT_PART) ? ID_PART_ADDR :
                        ID_MAKER_ADDR;
              end
              default: begin
                bus_go <= 1'b1;
                bus_rd <= 1'b0;
                bus_data <= CMD_READ;
                wait_cnt <= '0;
                ret <= M_RD_ISSUE;
                st <= M_BUS;
              end
            endcase
          end
        end
        M_BUS: begin
          if (bus_done) st <= (wait_cnt == '0) ? ret : M_WAIT;
        end
        M_WAIT: begin
          if (wait_cnt == '0) st <= ret;
          else wait_cnt <= wait_cnt - WAIT_W'(1);
        end
        M_RD_ISSUE, M_PGM_READ, M_EV_READ: begin
          bus_go <= 1'b1;
          bus_rd <= 1'b1;
          bus_addr <= addr;
          wait_cnt <= '0;
          ret <= (st == M_RD_ISSUE) ? M_RD_DONE :
                 (st == M_PGM_READ) ? M_PGM_CHECK : M_EV_CHECK;
          st <= M_BUS;
        end
        M_RD_DONE: begin
          RESULT_OUT <= rd_data;
          st <= M_END;
        end
        M_PGM_SETUP, M_PGM_DATA, M_PGM_VFY, M_ERS_SETUP, M_ERS_GO, M_EV_CMD,
        M_RST1, M_RST2, M_ID_CMD: begin
          bus_go <= 1'b1;
          bus_rd <= 1'b0;
          bus_addr <= addr;
          st <= M_BUS;
          wait_cnt <= '0;
          case (st)
            M_PGM_SETUP: begin
              bus_data <= CMD_PSETUP;
              ret <= M_PGM_DATA;
            end
            M_PGM_DATA: begin
              bus_data <= val;
              wait_cnt <= WAIT_W'(PGM_PULSE_CYC);
              ret <= M_PGM_VFY;
            end
            M_PGM_VFY: begin
              bus_data <= CMD_PVFY;
              wait_cnt <= WAIT_W'(REC_CYC);
              ret <= M_PGM_READ;
            end
            M_ERS_SETUP: begin
              bus_data <= CMD_ERASE;
              ret <= M_ERS_GO;
            end
            M_ERS_GO: begin
              bus_data <= CMD_ERASE;
              wait_cnt <= WAIT_W'(ERASE_PULSE_CYC);
              ret <= M_EV_CMD;
            end
            M_EV_CMD: begin
              bus_data <= CMD_EVFY;
              wait_cnt <= WAIT_W'(REC_CYC);
              ret <= M_EV_READ;
            end
            M_ID_CMD: begin
              bus_data <= CMD_IDENT;
              ret <= M_RD_ISSUE;
            end
            M_RST1: begin
              bus_data <= CMD_RESET;
              ret <= M_RST2;
            end
            default: begin
              bus_data <= CMD_RESET;
              ret <= M_END;
            end
          endcase
        end
        M_PGM_CHECK: begin
          if (rd_data == val) begin
            tries <= '0;
            if (!pre) begin
              st <= M_RST1;
            end else if (addr == {last, 1'b1}) begin
              pre <= 1'b0;
              addr <= '0;
              st <= M_ERS_SETUP;
            end else begin
              addr <= addr + ODD_BANK_START;
              st <= M_PGM_SETUP;
            end
          end else if (tries == TRY_W'(PGM_MAX_TRY - 1)) begin
            FAIL_OUT <= 1'b1;
            st <= M_RST1;
          end else begin
            tries <= tries + TRY_W'(1);
            st <= M_PGM_SETUP;
          end
        end
        M_EV_CHECK: begin
          if (rd_data == ERASED_VALUE) begin
            if (addr[ADDR_W-1:1] != last) begin
              addr <= addr + LOC_STEP;
              st <= M_EV_CMD;
            end else if (!addr[LANE_BIT]) begin
              addr <= ODD_BANK_START;
              tries <= '0;
              st <= M_ERS_SETUP;
            end else begin
              st <= M_RST1;
            end
          end else if (tries == TRY_W'(ERASE_MAX_TRY - 1)) begin
            FAIL_OUT <= 1'b1;
            st <= M_RST1;
          end else begin
            tries <= tries + TRY_W'(1);
            st <= M_ERS_SETUP;
          end
        end
        M_END: begin
          DONE_OUT <= 1'b1;
          CARD_VPP_EN_OUT <= 1'b0;
          st <= M_IDLE;
        end
        default: st <= M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------------
  logic we_q;
  logic we_rise;
  logic [7:0] cmd1;
  logic [7:0] cmd2;
  logic [ADDR_W-1:0] ev_addr;
  logic even_done;

  assign we_rise = CARD_WE_N_OUT && !we_q;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      we_q <= 1'b1;
      cmd1 <= 8'h00;
      cmd2 <= 8'h00;
      ev_addr <= '0;
      even_done <= 1'b0;
    end else begin
      we_q <= CARD_WE_N_OUT;
      if (we_rise) begin
        cmd1 <= CARD_DATA_OUT;
        cmd2 <= cmd1;
        if (CARD_DATA_OUT == CMD_EVFY) ev_addr <= CARD_ADDR_OUT;
      end
      if (st == M_IDLE) even_done <= 1'b0;
      else if (st == M_EV_CHECK && rd_data == ERASED_VALUE &&
               !addr[LANE_BIT] && addr[ADDR_W-1:1] == last)
        even_done <= 1'b1;
    end
  end

  sequence reset_again_s;
    ##[1:40] (we_rise && CARD_DATA_OUT == CMD_RESET);
  endsequence
  sequence erase_again_s;
    ##[1:40] (we_rise && CARD_DATA_OUT == CMD_ERASE &&
              CARD_ADDR_OUT == $past(addr));
  endsequence

  data_hold_a: assert property (we_rise |->
    CARD_DATA_OE_OUT && $stable(CARD_DATA_OUT))
    else $error("data not held through strobe rise");
  erase_stop_a: assert property (we_rise && cmd1 == CMD_ERASE &&
    cmd2 == CMD_ERASE |-> CARD_DATA_OUT == CMD_EVFY)
    else $error("running erase not ended by erase-verify");
  verify_cmd_a: assert property ($fell(CARD_OE_N_OUT) &&
    ret == M_EV_CHECK |-> cmd1 == CMD_EVFY && CARD_ADDR_OUT == ev_addr)
    else $error("erase-verify read without its command");
  verify_walk_a: assert property (we_rise && CARD_DATA_OUT == CMD_EVFY |->
    CARD_ADDR_OUT[ADDR_W-1:1] == ev_addr[ADDR_W-1:1] ||
    CARD_ADDR_OUT[ADDR_W-1:1] == ev_addr[ADDR_W-1:1] + LOC_W'(1) ||
    CARD_ADDR_OUT[ADDR_W-1:1] == '0)
    else $error("erase-verify address skipped");
  bank_order_a: assert property (we_rise && CARD_DATA_OUT == CMD_EVFY &&
    CARD_ADDR_OUT[LANE_BIT] |-> even_done)
    else $error("odd bank verified before even bank");
  preprog_a: assert property (we_rise && CARD_DATA_OUT == CMD_ERASE &&
    cmd1 != CMD_ERASE && cmd1 != CMD_PSETUP |-> op == OP_ERASE && !pre)
    else $error("erase set-up before zero fill finished");
  refail_a: assert property (st == M_EV_CHECK &&
    rd_data != ERASED_VALUE && tries != TRY_W'(ERASE_MAX_TRY - 1) |->
    erase_again_s)
    else $error("failed location not re-erased");
  reset_pair_a: assert property (we_rise && CARD_DATA_OUT == CMD_RESET &&
    cmd1 != CMD_RESET && cmd1 != CMD_PSETUP |-> reset_again_s)
    else $error("reset code not written twice");

endmodule

// ### fcs_card_model.sv
// Behavioural flash card segment that answers the host's command writes.
`timescale 1ns/1ps
module fcs_card_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'h5A,
  parameter logic [7:0] PART_CODE = 8'hC3
) (
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] data_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic ce_n_in,
  input wire logic vpp_in,
  input wire logic fail_en_in,
  input wire logic [ADDR_W-1:0] fail_loc_in,
  output logic [7:0] data_out,
  output logic [7:0] erase_cnt_out,
  output logic [7:0] pgm_cnt_out,
  output logic order_err_out
);
  // ----------------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    M_READ, M_IDENT, M_ESET, M_ERASE, M_EVFY, M_PSET, M_RST1, M_PGM, M_PVFY
  } fcs_mode_t;
  fcs_mode_t mode = M_READ;
  logic [7:0] mem [8];
  logic [ADDR_W-1:0] lat_addr = '0;
  logic [2:0] prog_loc = '0;
  logic [2:0] chk_loc = '0;
  logic inj = 1'b0;
  logic inj_used = 1'b0;
  logic odd_seen = 1'b0;
  logic hit;
  logic [7:0] rd;
  initial begin
    for (int i = 0; i < 8; i++) mem[i] = ERASED_VALUE;
    erase_cnt_out = '0;
    pgm_cnt_out = '0;
    order_err_out = 1'b0;
  end
  // One forced verify failure lets the bench see the host re-erase.
  assign hit = fail_en_in && !inj_used && lat_addr == fail_loc_in;
  always @(negedge we_n_in) begin
    if (!ce_n_in) lat_addr <= addr_in;
  end
  always @(posedge we_n_in) begin
    if (ce_n_in) begin
    end else if (!vpp_in) begin
      mode <= M_READ;
    end else if (mode == M_PSET && data_in != CMD_RESET) begin
      mem[lat_addr[2:0]] <= mem[lat_addr[2:0]] & data_in;
      prog_loc <= lat_addr[2:0];
      pgm_cnt_out <= pgm_cnt_out + 8'h01;
      odd_seen <= 1'b0;
      mode <= M_PGM;
    end else if (mode == M_PSET) begin
      mode <= M_RST1;
    end else if (mode == M_ESET && data_in == CMD_ERASE) begin
      mode <= M_ERASE;
      erase_cnt_out <= erase_cnt_out + 8'h01;
    end else begin
      if (mode == M_ERASE) begin
        for (int i = 0; i < 8; i++) mem[i] <= ERASED_VALUE;
      end
      case (data_in)
        CMD_IDENT: mode <= M_IDENT;
        CMD_ERASE: mode <= M_ESET;
        CMD_PSETUP: mode <= M_PSET;
        CMD_PVFY: mode <= M_PVFY;
        CMD_EVFY: begin
          mode <= M_EVFY;
          chk_loc <= lat_addr[2:0];
          inj <= hit;
          inj_used <= inj_used | hit;
          if (lat_addr[0]) odd_seen <= 1'b1;
          else if (odd_seen) order_err_out <= 1'b1;
        end
        default: mode <= M_READ;
      endcase
    end
  end
  always_comb begin
    case (mode)
      M_IDENT: rd = addr_in[0] ? PART_CODE : MAKER_CODE;
      M_PVFY: rd = mem[prog_loc];
      M_EVFY: rd = inj ? 8'h7F : mem[chk_loc];
      default: rd = mem[addr_in[2:0]];
    endcase
  end
  // A released bus shows the inverse so that a stale sample cannot pass.
  assign data_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
endmodule

// ### fcs_host_sequencer_test.sv
// Self-checking bench for the flash card host against a card model.
`timescale 1ns/1ps
module fcs_host_sequencer_test;
  import fcs_pkg::*;
  // Identification codes are arbitrary values.
  localparam logic [7:0] MAKER = 8'h5A;
  localparam logic [7:0] PART = 8'hC3;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  fcs_op_t req_op = OP_READ;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [LOC_W-1:0] req_last = '0;
  logic [7:0] req_data = '0;
  logic fail_en = 1'b0;
  logic [ADDR_W-1:0] fail_loc = 19'h00003;
  logic [7:0] bus, card_q, host_q, result, erase_cnt, pgm_cnt;
  logic [ADDR_W-1:0] card_addr;
  logic ready, done, fail, host_oe, we_n, oe_n, ce_n, vpp, order_err;
  int bad_count = 0;
  int n_compared = 0;
  always #4 clk = ~clk;
  assign bus = host_oe ? host_q : card_q;
  fcs_host_sequencer #(.ERASE_PULSE_CYC(20)) fcs_host_sequencer_i (
    .CORE_CLK_IN(clk), .SRST_IN(srst), .REQ_VALID_IN(req_valid),
    .REQ_OP_IN(req_op), .REQ_ADDR_IN(req_addr), .REQ_LAST_IN(req_last),
    .REQ_DATA_IN(req_data), .CARD_DATA_IN(bus), .REQ_READY_OUT(ready),
    .DONE_OUT(done), .FAIL_OUT(fail), .RESULT_OUT(result),
    .CARD_ADDR_OUT(card_addr), .CARD_DATA_OUT(host_q),
    .CARD_DATA_OE_OUT(host_oe), .CARD_WE_N_OUT(we_n),
    .CARD_OE_N_OUT(oe_n), .CARD_CE_N_OUT(ce_n), .CARD_VPP_EN_OUT(vpp));
  fcs_card_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) fcs_card_model_i (
    .addr_in(card_addr), .data_in(bus), .we_n_in(we_n), .oe_n_in(oe_n),
    .ce_n_in(ce_n), .vpp_in(vpp), .fail_en_in(fail_en),
    .fail_loc_in(fail_loc), .data_out(card_q), .erase_cnt_out(erase_cnt),
    .pgm_cnt_out(pgm_cnt), .order_err_out(order_err));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("Compared %0d, mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic ran_out();
    $display("CHECK FAILED t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
    bad_count++;
    test_done();
  endtask
  // Requests change only at rising edges; DONE is sampled at the edge.
  task automatic do_req(input fcs_op_t op, input logic [ADDR_W-1:0] a,
                        input logic [LOC_W-1:0] l, input logic [7:0] d,
                        input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 200);
    if (ready !== 1'b1) ran_out();
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_last <= l;
    req_data <= d;
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < lim);
    if (done !== 1'b1) ran_out();
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_ident();
    do_req(OP_IDENT_MAKER, '0, '0, 8'h00, 2000);
    chk(result, MAKER);
    do_req(OP_IDENT_PART, '0, '0, 8'h00, 2000);
    chk(result, PART);
    $display("ident test ended");
  endtask
  task automatic t_erase();
    logic [7:0] e0;
    logic [7:0] p0;
    e0 = erase_cnt;
    p0 = pgm_cnt;
    fail_en <= 1'b1;
    do_req(OP_ERASE, '0, 18'h00003, 8'h00, 60000);
    fail_en <= 1'b0;
    chk(pgm_cnt, p0 + 8'h08);
    chk(erase_cnt, e0 + 8'h03);
    chk({7'h00, order_err}, 8'h00);
    chk({7'h00, fail}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      do_req(OP_READ, ADDR_W'(i), '0, 8'h00, 500);
      chk(result, ERASED_VALUE);
    end
    $display("erase test ended");
  endtask
  task automatic t_program();
    do_req(OP_PROGRAM, 19'h00005, '0, 8'hA5, 5000);
    chk({7'h00, fail}, 8'h00);
    do_req(OP_PROGRAM, 19'h00002, '0, 8'h3C, 5000);
    do_req(OP_READ, 19'h00005, '0, 8'h00, 500);
    chk(result, 8'hA5);
    do_req(OP_READ, 19'h00002, '0, 8'h00, 500);
    chk(result, 8'h3C);
    $display("program test ended");
  endtask
  task automatic t_reset();
    do_req(OP_RESET, '0, '0, 8'h00, 500);
    do_req(OP_READ, 19'h00005, '0, 8'h00, 500);
    chk(result, 8'hA5);
    do_req(OP_READ, 19'h00004, '0, 8'h00, 500);
    chk(result, ERASED_VALUE);
    $display("reset test ended");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({3'h0, ce_n, we_n, oe_n, host_oe, vpp}, 8'h1C);
    t_ident();
    t_erase();
    t_program();
    t_reset();
    test_done();
  end
endmodule
